// [design/tcfg_pkg.sv]
// Shared constants for the tile configuration message handler.
package tcfg_pkg;
    localparam logic [7:0]  TOK_WR     = 8'hC0;     // Opening token of a write, 192.
    localparam logic [7:0]  TOK_RD     = 8'hC1;     // Opening token of a read, 193.
    localparam logic [7:0]  TOK_ACK    = 8'h03;
    localparam logic [7:0]  TOK_NAK    = 8'h04;
    localparam logic [7:0]  TOK_END    = 8'h01;
    localparam logic [7:0]  NO_REPLY   = 8'hFF;     // Low id byte that suppresses the reply to a write.
    localparam logic [7:0]  PS_RES_TAG = 8'h0C;     // Low byte of a status resource id.
    localparam logic [15:0] C20C_LOW   = 16'hC20C;  // Destination suffix the requester uses.
    localparam logic [1:0]  RID_LAST   = 2'h2;      // Index of the third identifier byte.
    localparam logic [1:0]  RNUM_LAST  = 2'h1;      // Index of the second register byte.
    localparam logic [1:0]  DATA_LAST  = 2'h3;      // Index of the fourth data byte.
    localparam logic [31:0] WORD_RST   = 32'h0000_0000;
    localparam int          NREG_DEF   = 8;         // Implemented configuration words.
    typedef enum logic [2:0] {
        TCFG_IDLE, TCFG_RID, TCFG_RNUM, TCFG_DATA, TCFG_END, TCFG_REPLY
    } tcfg_fsm_t;
endpackage

// [design/tcfg_regbank.sv]
// Configuration word store served by the message handler.
`timescale 1ns/1ps
module tcfg_regbank #(
    parameter int NREG = tcfg_pkg::NREG_DEF,
    parameter int AW   = 16
) (
    // Clock, reset and clock enable.
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          ce,
    // Access port.
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [31:0]   wdata,
    output logic      [31:0]   rdata
);
    import tcfg_pkg::*;

    typedef struct packed {
        logic [NREG-1:0][31:0] words;
    } tcfg_bank_t;

    tcfg_bank_t st;
    tcfg_bank_t next_st;

    // Writes outside the implemented range are dropped; the handler never issues them.
    always_comb begin
        next_st = st;
        if (we && addr < AW'(NREG)) begin
            next_st.words[addr] = wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // Read is combinational so the handler can latch it on the closing token.
    assign rdata = (addr < AW'(NREG)) ? st.words[addr] : WORD_RST;
endmodule

// [design/tcfg_handler.sv]
// Token message interpreter for tile configuration reads and writes.
`timescale 1ns/1ps
module tcfg_handler #(
    parameter int NREG = tcfg_pkg::NREG_DEF
) (
    // Clock, reset and clock enable.
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // Incoming request tokens.
    input  wire logic        in_valid,
    input  wire logic        in_ctrl,
    input  wire logic [7:0]  in_data,
    output logic             in_ready,
    // Outgoing reply tokens.
    output logic             out_valid,
    output logic             out_ctrl,
    output logic [7:0]       out_data,
    input  wire logic        out_ready,
    output logic [23:0]      out_dest,
    // Processor-status resource id of the last register number.
    output logic [31:0]      ps_res_id
);
    import tcfg_pkg::*;

    typedef struct packed {
        tcfg_fsm_t   fsm;
        logic [1:0]  cnt;
        logic [23:0] rid;
        logic [15:0] rnum;
        logic [31:0] data;
        logic        is_wr;
        logic        ok;
        logic [2:0]  idx;
        logic        ov;
        logic        oc;
        logic [7:0]  od;
        logic [31:0] psid;
    } tcfg_state_t;

    tcfg_state_t st;
    tcfg_state_t next_st;
    logic        acc;
    logic        fin;
    logic        fok;
    logic        reg_we;
    logic [31:0] rdata;
    logic [9:0]  t;

    // Reply token at position i: {last, ctrl, byte}.
    function automatic logic [9:0] tok(input logic [2:0] i, input logic ok,
                                       input logic rd, input logic [31:0] d);
        logic [9:0] r;
        r = {2'b11, TOK_END};
        if (ok && rd) begin
            case (i)
                3'd0:    r = {2'b01, TOK_ACK};
                3'd1:    r = {2'b00, d[31:24]};
                3'd2:    r = {2'b00, d[23:16]};
                3'd3:    r = {2'b00, d[15:8]};
                3'd4:    r = {2'b00, d[7:0]};
                default: r = {2'b11, TOK_END};
            endcase
        end else if (i == 3'd0) begin
            r = {2'b01, ok ? TOK_ACK : TOK_NAK};
        end
        return r;
    endfunction

    tcfg_regbank #(.NREG(NREG), .AW(16)) u_bank (
        .clk   (clk),
        .rst   (rst),
        .ce    (ce),
        .we    (reg_we),
        .addr  (st.rnum),
        .wdata (st.data),
        .rdata (rdata)
    );

    // Requests are only accepted while parsing; replies hold the input off.
    assign in_ready = ce && st.fsm != TCFG_REPLY;
    assign acc      = in_valid && in_ready;
    // A write lands only on a well-formed closing token naming a real register.
    assign reg_we   = acc && st.fsm == TCFG_END && st.is_wr && in_ctrl &&
                      in_data == TOK_END && st.rnum < 16'(NREG);

    // Parser and reply sequencer.
    always_comb begin
        next_st = st;
        fin     = 1'b0;
        fok     = 1'b0;
        t       = '0;
        case (st.fsm)
            TCFG_IDLE: begin
                // Stray tokens between messages are discarded.
                if (acc && in_ctrl && (in_data == TOK_WR || in_data == TOK_RD)) begin
                    next_st.is_wr = (in_data == TOK_WR);
                    // A fresh message never inherits the id of the one before it.
                    next_st.rid   = '0;
                    next_st.fsm   = TCFG_RID;
                    next_st.cnt   = '0;
                end
            end
            TCFG_RID: begin
                if (acc) begin
                    if (in_ctrl) begin
                        fin = 1'b1;
                    end else begin
                        next_st.rid = {st.rid[15:0], in_data};
                        next_st.cnt = st.cnt + 2'd1;
                        if (st.cnt == RID_LAST) begin
                            next_st.fsm = TCFG_RNUM;
                            next_st.cnt = '0;
                        end
                    end
                end
            end
            TCFG_RNUM: begin
                if (acc) begin
                    if (in_ctrl) begin
                        fin = 1'b1;
                    end else begin
                        next_st.rnum = {st.rnum[7:0], in_data};
                        next_st.cnt  = st.cnt + 2'd1;
                        if (st.cnt == RNUM_LAST) begin
                            next_st.psid = {8'h00, st.rnum[7:0], in_data, PS_RES_TAG};
                            next_st.fsm  = st.is_wr ? TCFG_DATA : TCFG_END;
                            next_st.cnt  = '0;
                        end
                    end
                end
            end
            TCFG_DATA: begin
                if (acc) begin
                    if (in_ctrl) begin
                        fin = 1'b1;
                    end else begin
                        next_st.data = {st.data[23:0], in_data};
                        next_st.cnt  = st.cnt + 2'd1;
                        if (st.cnt == DATA_LAST) begin
                            next_st.fsm = TCFG_END;
                        end
                    end
                end
            end
            TCFG_END: begin
                if (acc) begin
                    fin = 1'b1;
                    fok = in_ctrl && in_data == TOK_END && st.rnum < 16'(NREG);
                    if (fok && !st.is_wr) begin
                        next_st.data = rdata;
                    end
                end
            end
            TCFG_REPLY: begin
                if (out_ready && st.ov) begin
                    if (st.idx == 3'd5 || (st.idx == 3'd1 && !(st.ok && !st.is_wr))) begin
                        next_st.fsm = TCFG_IDLE;
                        next_st.ov  = 1'b0;
                    end else begin
                        t          = tok(st.idx + 3'd1, st.ok, !st.is_wr, st.data);
                        next_st.idx = st.idx + 3'd1;
                        next_st.oc  = t[8];
                        next_st.od  = t[7:0];
                    end
                end
            end
            default: next_st.fsm = TCFG_IDLE;
        endcase
        // Finishing a message: a write whose id ends in FF is silent.
        if (fin) begin
            next_st.ok = fok;
            if (st.is_wr && st.rid[7:0] == NO_REPLY) begin
                next_st.fsm = TCFG_IDLE;
            end else begin
                t           = tok(3'd0, fok, !st.is_wr, rdata);
                next_st.fsm = TCFG_REPLY;
                next_st.idx = '0;
                next_st.ov  = 1'b1;
                next_st.oc  = t[8];
                next_st.od  = t[7:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // Reply valid is gated by ce so a frozen block never offers a token.
    assign out_valid = st.ov && ce;
    assign out_ctrl  = st.oc;
    assign out_data  = st.od;
    assign out_dest  = st.rid;
    assign ps_res_id = st.psid;

    logic hs;
    logic wr_done;
    assign hs      = out_valid && out_ready;
    assign wr_done = acc && st.fsm == TCFG_END && st.is_wr;

    property p_rid_shift;
        @(posedge clk) disable iff (rst)
        acc && st.fsm == TCFG_RID && st.cnt == RID_LAST && !in_ctrl
        |=> st.rid[7:0] == $past(in_data) && st.fsm == TCFG_RNUM;
    endproperty
    a_rid_shift: assert property (p_rid_shift) else $error("id byte lost");

    property p_silent;
        @(posedge clk) disable iff (rst)
        wr_done && st.rid[7:0] == NO_REPLY |=> !st.ov [*2];
    endproperty
    a_silent: assert property (p_silent) else $error("reply not suppressed");

    property p_msb_first;
        @(posedge clk) disable iff (rst)
        hs && st.idx == 3'd0 && st.ok && !st.is_wr
        |=> out_data == st.data[31:24] && !out_ctrl;
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("word not msb first");

    property p_psid;
        @(posedge clk) disable iff (rst)
        acc && st.fsm == TCFG_RNUM && st.cnt == RNUM_LAST && !in_ctrl
        |=> ps_res_id == {8'h00, $past(st.rnum[7:0]), $past(in_data), PS_RES_TAG};
    endproperty
    a_psid: assert property (p_psid) else $error("bad status resource id");

    property p_wr_reply;
        @(posedge clk) disable iff (rst)
        wr_done && st.rid[7:0] != NO_REPLY
        |=> st.ov && st.oc &&
            st.od == ($past(in_ctrl && in_data == TOK_END && st.rnum < 16'(NREG)) ?
                      TOK_ACK : TOK_NAK);
    endproperty
    a_wr_reply: assert property (p_wr_reply) else $error("bad write reply");

    property p_rd_len;
        @(posedge clk) disable iff (rst)
        hs && st.idx == 3'd0 && out_data == TOK_ACK && !st.is_wr
        |=> !out_ctrl ##1 (!out_ctrl || !hs) ##0 st.idx >= 3'd1;
    endproperty
    a_rd_len: assert property (p_rd_len) else $error("read reply too short");

    property p_nak_end;
        @(posedge clk) disable iff (rst)
        hs && out_ctrl && out_data == TOK_NAK
        |=> st.ov && st.oc && st.od == TOK_END;
    endproperty
    a_nak_end: assert property (p_nak_end) else $error("fail not closed");

    // Any accepted token but a good closing write must leave the store untouched.
    property p_no_bad_we;
        @(posedge clk) disable iff (rst)
        acc && !(st.fsm == TCFG_END && st.is_wr && in_ctrl && in_data == TOK_END &&
                 st.rnum < 16'(NREG))
        |=> $stable(u_bank.st);
    endproperty
    a_no_bad_we: assert property (p_no_bad_we) else $error("bad register written");

    c_read:  cover property (@(posedge clk) hs && st.idx == 3'd5);
    c_write: cover property (@(posedge clk) wr_done && fok);
    c_fail:  cover property (@(posedge clk) hs && out_data == TOK_NAK && out_ctrl);
endmodule

// [verification/tcfg_req_model.sv]
// Requesting channel-end model that sends token messages and collects the replies.
`timescale 1ns/1ps
module tcfg_req_model #(
    parameter logic [15:0] TILE_ID = 16'h0001  // Arbitrary tile number for this bench.
) (
    // Clock.
    input  wire logic       clk,
    // Request tokens toward the handler.
    output logic            in_valid,
    output logic            in_ctrl,
    output logic [7:0]      in_data,
    input  wire logic       in_ready,
    // Reply tokens from the handler.
    input  wire logic       out_valid,
    input  wire logic       out_ctrl,
    input  wire logic [7:0] out_data,
    output logic            out_ready
);
    import tcfg_pkg::*;
    // Destination the channel-end is set to; only the tile part is ours to choose.
    localparam logic [31:0] DEST = {TILE_ID, C20C_LOW};
    logic       slow;
    logic [8:0] q[$];

    // Idle request lines at time zero.
    initial begin
        in_valid  = 1'b0;
        in_ctrl   = 1'b0;
        in_data   = 8'h00;
        out_ready = 1'b0;
        slow      = 1'b0;
    end

    // Reply sink; when stalling it accepts only every second cycle.
    always @(posedge clk) begin
        if (out_valid && out_ready) begin
            q.push_back({out_ctrl, out_data});
        end
        out_ready <= slow ? ~out_ready : 1'b1;
    end

    // One token, held until taken; in_ready is stable at the falling edge.
    task automatic put(input logic c, input logic [7:0] d);
        in_valid <= 1'b1;
        in_ctrl  <= c;
        in_data  <= d;
        do @(negedge clk); while (in_ready !== 1'b1);
        @(posedge clk);
    endtask

    // Release the lines; data shows the inverse so a stale byte is never mistaken.
    task automatic stop();
        in_valid <= 1'b0;
        in_data  <= ~in_data;
    endtask

    // Whole message, every field most significant byte first.
    task automatic req(input logic wr, input logic [23:0] rid, input logic [15:0] rn,
                       input logic [31:0] d);
        put(1'b1, wr ? TOK_WR : TOK_RD);
        for (int i = 2; i >= 0; i--) put(1'b0, rid[8*i +: 8]);
        for (int i = 1; i >= 0; i--) put(1'b0, rn[8*i +: 8]);
        if (wr) for (int i = 3; i >= 0; i--) put(1'b0, d[8*i +: 8]);
        put(1'b1, TOK_END);
        stop();
    endtask
endmodule

// [verification/tcfg_handler_test.sv]
// Self-checking bench for the tile configuration message handler.
`timescale 1ns/1ps
module tcfg_handler_test;
    import tcfg_pkg::*;
    localparam int NR = 8;
    logic        clk, rst, ce, in_valid, in_ctrl, in_ready, out_valid, out_ctrl, out_ready;
    logic [7:0]  in_data, out_data;
    logic [23:0] out_dest;
    logic [31:0] ps_res_id;
    int          n_fail = 0;
    int          checked = 0;

    tcfg_handler #(.NREG(NR)) DUT (.clk(clk), .rst(rst), .ce(ce), .in_valid(in_valid),
        .in_ctrl(in_ctrl), .in_data(in_data), .in_ready(in_ready), .out_valid(out_valid),
        .out_ctrl(out_ctrl), .out_data(out_data), .out_ready(out_ready),
        .out_dest(out_dest), .ps_res_id(ps_res_id));
    tcfg_req_model M (.clk(clk), .in_valid(in_valid), .in_ctrl(in_ctrl),
        .in_data(in_data), .in_ready(in_ready), .out_valid(out_valid),
        .out_ctrl(out_ctrl), .out_data(out_data), .out_ready(out_ready));

    // Compare and count.
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Next reply token, waited for under a bound; a missing token reads as 1FF.
    task automatic tok(input logic [8:0] e);
        int i;
        i = 0;
        while (M.q.size() == 0 && i < 200) begin
            @(posedge clk);
            i++;
        end
        chk("reply token", (M.q.size() != 0) ? M.q.pop_front() : 9'h1FF, e);
    endtask

    // Short reply of success or failure.
    task automatic ack(input logic ok);
        tok({1'b1, ok ? TOK_ACK : TOK_NAK});
        tok({1'b1, TOK_END});
    endtask

    // Successful read reply carrying a word.
    task automatic rd_ok(input logic [31:0] d);
        tok({1'b1, TOK_ACK});
        for (int i = 3; i >= 0; i--) tok({1'b0, d[8*i +: 8]});
        tok({1'b1, TOK_END});
    endtask

    task automatic t_write_read();
        M.req(1'b1, 24'h12_3401, 16'h0003, 32'hA5C3_0F12);
        ack(1'b1);
        chk("reply channel-end", {8'h00, out_dest}, 32'h0012_3401);
        chk("status resource id", ps_res_id, 32'h0000_030C);
        M.slow <= 1'b1;
        M.req(1'b0, 24'h00_5602, 16'h0003, 32'h0000_0000);
        rd_ok(32'hA5C3_0F12);
        M.slow <= 1'b0;
        $display("test write_read done");
    endtask

    task automatic t_silent();
        M.req(1'b1, 24'h00_00FF, 16'h0005, 32'h0000_0055);
        repeat (20) @(posedge clk);
        chk("replies to silent write", M.q.size(), 32'h0000_0000);
        M.req(1'b0, 24'h00_0103, 16'h0005, 32'h0000_0000);
        rd_ok(32'h0000_0055);
        chk("reply channel-end", {8'h00, out_dest}, 32'h0000_0103);
        chk("status resource id", ps_res_id, 32'h0000_050C);
        $display("test silent done");
    endtask

    task automatic t_refuse();
        M.req(1'b0, 24'h00_0104, 16'h0008, 32'h0000_0000);
        ack(1'b0);
        M.req(1'b1, 24'h00_0105, 16'h0100, 32'hFFFF_FFFF);
        ack(1'b0);
        M.req(1'b0, 24'h00_0106, 16'h0000, 32'h0000_0000);
        rd_ok(32'h0000_0000);
        $display("test refuse done");
    endtask

    // Closing token arrives in place of the third data byte.
    task automatic t_malformed();
        M.put(1'b1, TOK_WR);
        M.put(1'b0, 8'h00);
        M.put(1'b0, 8'h01);
        M.put(1'b0, 8'h07);
        M.put(1'b0, 8'h00);
        M.put(1'b0, 8'h03);
        M.put(1'b0, 8'h11);
        M.put(1'b0, 8'h22);
        M.put(1'b1, TOK_END);
        M.stop();
        ack(1'b0);
        // A stray data byte is dropped; a read cut short in its id fails at once.
        M.put(1'b0, 8'h5A);
        M.put(1'b1, TOK_RD);
        M.put(1'b0, 8'h00);
        M.put(1'b1, TOK_END);
        M.stop();
        ack(1'b0);
        M.req(1'b0, 24'h00_0108, 16'h0003, 32'h0000_0000);
        rd_ok(32'hA5C3_0F12);
        $display("test malformed done");
    endtask

    // Clock enable drops as a read reply is due; nothing may move until it returns.
    task automatic t_freeze();
        M.req(1'b0, 24'h00_0109, 16'h0003, 32'h0000_0000);
        ce <= 1'b0;
        repeat (10) @(posedge clk);
        chk("tokens while frozen", M.q.size(), 32'h0000_0000);
        chk("reply offered while frozen", {31'h0, out_valid}, 32'h0000_0000);
        chk("request ready while frozen", {31'h0, in_ready}, 32'h0000_0000);
        ce <= 1'b1;
        rd_ok(32'hA5C3_0F12);
        $display("test freeze done");
    endtask

    // Counts, verdict and end of run.
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Clock of 20 ns.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Reset for five cycles, then the tests; only the freeze test lowers clock enable.
    initial begin
        rst = 1'b1;
        ce  = 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_write_read();
        t_silent();
        t_refuse();
        t_malformed();
        t_freeze();
        print_verdict();
    end

    // Watchdog far beyond the few hundred cycles the tests need.
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        $display("BAD watchdog expired");
        print_verdict();
    end
endmodule
